// [logic/bit_ops_top.sv]
// How it works
// RULE1 - true bit test sets condition flag when chosen bit is one, else clears
// RULE2 - inverted bit test sets condition flag when chosen bit is zero
// RULE3 - bit position is five-bit unsigned, 0 is lsb, 31 is msb
// RULE4 - bit test changes no data bits and no flag but condition flag
// RULE5 - bit test is accepted only as a 16-bit instruction word
// RULE6 - bit test is refused when issued in a parallel group
// RULE7 - deposit merges foreground bits 31:16 into background, writes destination
// RULE8 - second operand: foreground 31:16, position 12:8, length 4:0, rest ignored
// RULE9 - position 0..31, length 0..16; only low length foreground bits used
// RULE10 - field overwrites background from target position, foreground lsb at position
// RULE11 - plain deposit with zero length returns background unchanged
// RULE12 - extended deposit with zero length and zero position gives zero
// RULE13 - extended, zero length, nonzero position: sign-extend background below position
// RULE14 - extended deposit drops foreground bits landing above bit 31
// RULE15 - extended: bits below from background, above copy field msb
// RULE16 - sources unchanged unless chosen as destination; destination may be a source
// RULE17 - deposit sets zero and negative from result, clears carry, overflow
// RULE18 - deposit is 32-bit; parallel only with a 16-bit partner
// RULE19 - toggle inverts only the chosen bit; twice restores the word
// RULE20 - plain deposit keeps background outside field, drops bits above 31
//
// Our own choices: the address map and register access over Wishbone.
`include "bit_ops_consts.svh"

module bit_ops_top import bit_ops_pkg::*; (
	input wire logic clk_i, // core clock, 50 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic [7:0] adr_i, // wishbone byte address
	input wire logic [31:0] dat_i, // wishbone write data
	input wire logic [3:0] sel_i, // wishbone byte enables
	input wire logic we_i, // wishbone write enable
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	output logic [31:0] dat_o, // wishbone read data
	output logic ack_o, // wishbone acknowledge
	output logic condition_flag_o, // condition flag
	output logic zero_flag_o, // zero flag
	output logic negative_flag_o, // negative flag
	output logic carry_flag_o, // carry flag
	output logic overflow_flag_o // overflow flag
);

	// ****************************************
	// state
	// ****************************************
	word_t opa_r;
	word_t opb_r;
	word_t cmd_r;
	word_t res_r;
	flags_s flags_r;
	logic rej_r;
	logic [7:0] exec_cnt_r;
	bus_st_e st_r;
	logic ack_r;
	word_t dat_r;

	// ****************************************
	// byte-lane merge
	// ****************************************
	function automatic word_t lane_merge(
		input word_t old_w,
		input word_t new_w,
		input logic [3:0] sel
	);
		word_t m;
		m = old_w;
		for (int i = 0; i < `LANES; i++) begin
			if (sel[i]) begin
				m[i * `LANE_W +: `LANE_W] = new_w[i * `LANE_W +: `LANE_W];
			end
		end
		return m;
	endfunction : lane_merge

	// ****************************************
	// bus decode
	// ****************************************
	logic req;
	logic wr_acc;
	logic wr_opa;
	logic wr_opb;
	logic wr_cmd;
	logic wr_flg;

	// a write lands on the edge where ack is high, matching what the master samples
	assign req = cyc_i & stb_i;
	assign wr_acc = req & we_i & (st_r == st_ack);
	assign wr_opa = wr_acc & (adr_i == `ADR_OPA);
	assign wr_opb = wr_acc & (adr_i == `ADR_OPB);
	assign wr_cmd = wr_acc & (adr_i == `ADR_CMD);
	assign wr_flg = wr_acc & (adr_i == `ADR_FLG);

	// ****************************************
	// command decode
	// ****************************************
	word_t cmd_word;
	op_e op;
	logic [4:0] bit_pos;
	logic wide;
	logic par;
	logic part16;
	logic [1:0] dst;
	logic legal;
	logic is_test;
	logic is_toggle;
	logic is_deposit;

	always_comb begin
		cmd_word = lane_merge(cmd_r, dat_i, sel_i);
		op = op_e'(cmd_word[`CMD_OP_MSB:`CMD_OP_LSB]);
		bit_pos = cmd_word[`CMD_POS_MSB:`CMD_POS_LSB]; // RULE3
		wide = cmd_word[`CMD_WIDE_BIT];
		par = cmd_word[`CMD_PAR_BIT];
		part16 = cmd_word[`CMD_PART16_BIT];
		dst = cmd_word[`CMD_DST_MSB:`CMD_DST_LSB];
		is_test = 1'b0;
		is_toggle = 1'b0;
		is_deposit = 1'b0;
		legal = 1'b0;
		case (op)
			op_test_true, op_test_inv: begin
				is_test = 1'b1;
				legal = ~wide & ~par; // RULE5 RULE6
			end
			op_toggle: begin
				is_toggle = 1'b1;
				legal = ~wide & ~par;
			end
			op_deposit, op_deposit_x: begin
				is_deposit = 1'b1;
				legal = wide & (~par | part16); // RULE18
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	logic exec;
	assign exec = wr_cmd & legal;

	// ****************************************
	// datapath
	// ****************************************
	field_bus_if dep_bus ();

	assign dep_bus.background = opa_r; // RULE7
	assign dep_bus.operand = opb_r; // RULE8
	assign dep_bus.sign_ext = (op == op_deposit_x);

	field_deposit_unit u_deposit (
		.dep(dep_bus)
	);

	logic tested_bit;
	word_t toggled;
	word_t dep_res;

	assign tested_bit = opa_r[bit_pos]; // RULE3
	assign toggled = opa_r ^ (`WORD_ONE << bit_pos); // RULE19
	assign dep_res = dep_bus.merged;

	// ****************************************
	// bus handshake
	// ****************************************
	// ack rises one cycle after the request and falls the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= st_idle;
			ack_r <= 1'b0;
		end else if (ce_i) begin
			unique case (st_r)
				st_idle: begin
					if (req) begin
						st_r <= st_ack;
						ack_r <= 1'b1;
					end
				end
				st_ack: begin
					st_r <= st_idle;
					ack_r <= 1'b0;
				end
				default: begin
					st_r <= st_idle;
					ack_r <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= `WORD_ZERO;
		end else if (ce_i) begin
			if (st_r == st_idle && req && !we_i) begin
				case (adr_i)
					`ADR_OPA: dat_r <= opa_r;
					`ADR_OPB: dat_r <= opb_r;
					`ADR_CMD: dat_r <= cmd_r;
					`ADR_RES: dat_r <= res_r;
					`ADR_FLG: dat_r <= word_t'(flags_r);
					`ADR_STS: begin
						dat_r <= `WORD_ZERO;
						dat_r[`STS_CNT_MSB:`STS_CNT_LSB] <= exec_cnt_r;
						dat_r[`STS_REJ_BIT] <= rej_r;
					end
					default: dat_r <= `WORD_ZERO;
				endcase
			end else if (st_r == st_ack) begin
				// keep stale data off the bus between transfers
				dat_r <= `WORD_ZERO;
			end
		end
	end

	// ****************************************
	// data operand
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opa_r <= `WORD_ZERO;
		end else if (ce_i) begin
			if (wr_opa) begin
				opa_r <= lane_merge(opa_r, dat_i, sel_i);
			end else if (exec && is_toggle) begin
				opa_r <= toggled; // RULE19
			end else if (exec && is_deposit && dst == `DST_OPA) begin
				opa_r <= dep_res; // RULE16
			end
			// a bit test never writes here
		end
	end

	// ****************************************
	// second operand
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opb_r <= `WORD_ZERO;
		end else if (ce_i) begin
			if (wr_opb) begin
				opb_r <= lane_merge(opb_r, dat_i, sel_i);
			end else if (exec && is_deposit && dst == `DST_OPB) begin
				opb_r <= dep_res; // RULE16
			end
		end
	end

	// ****************************************
	// command and result
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= `WORD_ZERO;
		end else if (ce_i) begin
			if (wr_cmd) begin
				cmd_r <= cmd_word;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_r <= `WORD_ZERO;
		end else if (ce_i) begin
			if (exec && is_toggle) begin
				res_r <= toggled;
			end else if (exec && is_deposit) begin
				res_r <= dep_res; // RULE7
			end
		end
	end

	// ****************************************
	// flags
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= flags_s'(`WORD_ZERO);
		end else if (ce_i) begin
			if (wr_flg) begin
				flags_r <= flags_s'(lane_merge(word_t'(flags_r), dat_i, sel_i));
			end else if (exec && is_test) begin
				// the other four flags keep their value
				if (op == op_test_true) begin
					flags_r.condition_flag <= tested_bit; // RULE1 RULE4
				end else begin
					flags_r.condition_flag <= ~tested_bit; // RULE2 RULE4
				end
			end else if (exec && is_deposit) begin
				flags_r.zero_flag <= (dep_res == `WORD_ZERO); // RULE17
				flags_r.negative_flag <= dep_res[`WORD_MSB]; // RULE17
				flags_r.carry_flag <= 1'b0; // RULE17
				flags_r.overflow_flag <= 1'b0; // RULE17
			end else if (exec && is_toggle) begin
				flags_r.zero_flag <= (toggled == `WORD_ZERO);
				flags_r.negative_flag <= toggled[`WORD_MSB];
				flags_r.carry_flag <= 1'b0;
				flags_r.overflow_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// status
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rej_r <= 1'b0;
		end else if (ce_i) begin
			if (wr_cmd) begin
				rej_r <= ~legal; // RULE5 RULE6 RULE18
			end
		end
	end

	// wraps silently; software only needs to see that something ran
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exec_cnt_r <= `CNT_ZERO;
		end else if (ce_i) begin
			if (exec) begin
				exec_cnt_r <= exec_cnt_r + `CNT_ONE;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign condition_flag_o = flags_r.condition_flag;
	assign zero_flag_o = flags_r.zero_flag;
	assign negative_flag_o = flags_r.negative_flag;
	assign carry_flag_o = flags_r.carry_flag;
	assign overflow_flag_o = flags_r.overflow_flag;

endmodule : bit_ops_top

// [inc/bit_ops_consts.svh]
`ifndef BIT_OPS_CONSTS_SVH
`define BIT_OPS_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADR_OPA 8'h00
`define ADR_OPB 8'h04
`define ADR_CMD 8'h08
`define ADR_RES 8'h0c
`define ADR_FLG 8'h10
`define ADR_STS 8'h14

// ****************************************
// command word fields
// ****************************************
`define CMD_OP_MSB 2
`define CMD_OP_LSB 0
`define CMD_POS_MSB 12
`define CMD_POS_LSB 8
`define CMD_WIDE_BIT 16
`define CMD_PAR_BIT 17
`define CMD_PART16_BIT 18
`define CMD_DST_MSB 21
`define CMD_DST_LSB 20
`define DST_OPA 2'h1
`define DST_OPB 2'h2

// ****************************************
// deposit operand fields
// ****************************************
`define FG_MSB 31
`define FG_LSB 16
`define DPOS_MSB 12
`define DPOS_LSB 8
`define DLEN_MSB 4
`define DLEN_LSB 0
`define DLEN_MAX 5'h10
`define FG_ONE 16'h0001
`define FG_ZERO 16'h0000

// ****************************************
// flags and status
// ****************************************
`define FLG_MSB 4
`define STS_REJ_BIT 0
`define STS_CNT_MSB 15
`define STS_CNT_LSB 8
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00

// ****************************************
// word constants
// ****************************************
`define WORD_ZERO 32'h0000_0000
`define WORD_ONES 32'hffff_ffff
`define WORD_ONE 32'h0000_0001
`define WORD_MSB 31
`define TOP_FULL 6'h20
`define LANE_W 8
`define LANES 4

`endif

// [inc/bit_ops_pkg.sv]
package bit_ops_pkg;

	typedef logic [31:0] word_t;

	typedef enum logic [2:0] {
		op_test_true = 3'h1,
		op_test_inv = 3'h2,
		op_toggle = 3'h3,
		op_deposit = 3'h4,
		op_deposit_x = 3'h5
	} op_e;

	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_ack = 2'b10
	} bus_st_e;

	typedef struct packed {
		logic overflow_flag;
		logic carry_flag;
		logic negative_flag;
		logic zero_flag;
		logic condition_flag;
	} flags_s;

endpackage : bit_ops_pkg

// [inc/field_bus_if.sv]
interface field_bus_if;
	bit_ops_pkg::word_t background;
	bit_ops_pkg::word_t operand;
	logic sign_ext;
	bit_ops_pkg::word_t merged;

	modport core (
		output background,
		output operand,
		output sign_ext,
		input merged
	);

	modport unit (
		input background,
		input operand,
		input sign_ext,
		output merged
	);
endinterface : field_bus_if

// [logic/field_deposit_unit.sv]
`include "bit_ops_consts.svh"

module field_deposit_unit import bit_ops_pkg::*; (
	field_bus_if.unit dep // deposit operands and merged word
);

	logic [4:0] len;
	logic [4:0] pos;
	logic [4:0] sign_idx;
	logic [5:0] top;
	logic [15:0] fg_mask;
	word_t fmask;
	word_t placed;
	word_t merged_w;
	word_t upper;
	logic sign;

	always_comb begin
		len = dep.operand[`DLEN_MSB:`DLEN_LSB]; // RULE8
		pos = dep.operand[`DPOS_MSB:`DPOS_LSB]; // RULE8
		// lengths beyond the valid range saturate rather than wrap
		if (len > `DLEN_MAX) begin
			len = `DLEN_MAX; // RULE9
		end
		// a 16-bit shift by 16 wraps to zero, so the mask becomes all ones
		fg_mask = (`FG_ONE << len) - `FG_ONE; // RULE9
		fmask = {`FG_ZERO, fg_mask} << pos; // RULE14 RULE20
		placed = {`FG_ZERO, dep.operand[`FG_MSB:`FG_LSB] & fg_mask} << pos; // RULE7 RULE10
		merged_w = (dep.background & ~fmask) | placed; // RULE10 RULE11 RULE20
		top = {1'b0, pos} + {1'b0, len};
		upper = `WORD_ONES << top;
		sign_idx = top[4:0] - 5'h1;
		// an empty field at position zero has a zero sign
		sign = (top == 6'h00) ? 1'b0 : merged_w[sign_idx]; // RULE12 RULE13
		if (dep.sign_ext) begin
			dep.merged = (merged_w & ~upper) | (sign ? upper : `WORD_ZERO); // RULE15 RULE14
		end else begin
			dep.merged = merged_w;
		end
	end

endmodule : field_deposit_unit

// [verification/flag_props_properties.sv]
`include "bit_ops_consts.svh"

module flag_props import bit_ops_pkg::*; (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // sync reset
	input wire logic ce_i, // clock enable
	input wire logic [7:0] adr_i, // byte address
	input wire logic [31:0] dat_i, // write data
	input wire logic [3:0] sel_i, // byte enables
	input wire logic we_i, // write enable
	input wire logic cyc_i, // cycle
	input wire logic stb_i, // strobe
	input wire logic [31:0] dat_o, // read data
	input wire logic ack_o, // acknowledge
	input wire logic condition_flag_o, // condition flag
	input wire logic zero_flag_o, // zero flag
	input wire logic negative_flag_o, // negative flag
	input wire logic carry_flag_o, // carry flag
	input wire logic overflow_flag_o // overflow flag
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// command decode seen at the ack edge
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic cmd_wr;
	logic tst;
	logic dep_ok;
	assign cmd_wr = ack_o && we_i && adr_i == `ADR_CMD && sel_i == 4'hf;
	assign tst = cmd_wr && (dat_i[2:0] == 3'h1 || dat_i[2:0] == 3'h2);
	assign dep_ok = cmd_wr && dat_i[2:1] == 2'b10 && dat_i[16] && !dat_i[17];
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_timing_a: assert property ($rose(cyc_i && stb_i) && ce_i |=> ack_o)
		else $error("ack missing one cycle after request");
	idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	test_keeps_a: assert property (tst |=>
		$stable({zero_flag_o, negative_flag_o, carry_flag_o, overflow_flag_o}))
		else $error("bit test touched other flags");
	test_refused_a: assert property (tst && (dat_i[16] || dat_i[17]) |=>
		$stable(condition_flag_o))
		else $error("illegal bit test changed condition flag");
	dep_clears_a: assert property (dep_ok |=> !carry_flag_o && !overflow_flag_o)
		else $error("deposit left carry or overflow");
	dep_sign_a: assert property (dep_ok |=> !(zero_flag_o && negative_flag_o))
		else $error("zero and negative both set");
	ce_freeze_a: assert property (!ce_i |=> $stable({ack_o, condition_flag_o,
		zero_flag_o, negative_flag_o, carry_flag_o, overflow_flag_o}))
		else $error("state moved with clock enable low");
endmodule : flag_props

bind bit_ops_top flag_props flag_props_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .condition_flag_o(condition_flag_o),
	.zero_flag_o(zero_flag_o), .negative_flag_o(negative_flag_o),
	.carry_flag_o(carry_flag_o), .overflow_flag_o(overflow_flag_o));

// [verification/decoder_model.sv]
module decoder_model import bit_ops_pkg::*; (
	input wire logic clk_i, // core clock
	input wire logic ack_i, // slave acknowledge
	input wire logic [31:0] rdat_i, // read data
	output logic [7:0] adr_o, // byte address
	output logic [31:0] dat_o, // write data
	output logic [3:0] sel_o, // byte enables
	output logic we_o, // write enable
	output logic cyc_o, // cycle
	output logic stb_o // strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{cyc_o, stb_o, we_o} = 3'h0;
		adr_o = 8'h00;
		dat_o = 32'h0;
		sel_o = 4'h0;
	end
	// ****
	// classic single wishbone cycle
	// ****
	task automatic xfer(input logic w, input logic [7:0] a, input word_t d, output word_t q);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o} <= {2'b11, w};
		adr_o <= a;
		dat_o <= d;
		sel_o <= 4'hf;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = rdat_i;
		{cyc_o, stb_o, we_o} <= 3'h0;
		// idle bus shows junk so a stale value never passes for a good one
		adr_o <= ~a;
		dat_o <= ~d;
	endtask : xfer
endmodule : decoder_model

// [verification/tb_top.sv]
`include "bit_ops_consts.svh"

module tb_top import bit_ops_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, ce, we, cyc, stb, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	word_t wdat, rdat, w, e, q;
	flags_s f;
	int num_errors, compares, i;
	word_t tbl [10][3] = '{
		'{32'hffff_ffff, 32'h5a5a_0703, 32'h0001_0005},
		'{32'hffff_ffff, 32'h5a5a_0703, 32'h0001_0004},
		'{32'h0000_8123, 32'h1234_1000, 32'h0001_0005},
		'{32'h1234_5678, 32'habcd_0000, 32'h0001_0005},
		'{32'h1234_5678, 32'habcd_1f00, 32'h0021_0004},
		'{32'h0000_0000, 32'hffff_1c10, 32'h0001_0005},
		'{32'h89ab_cdef, 32'hffff_1e10, 32'h0011_0004},
		'{32'h0000_0000, 32'h0000_0510, 32'h0007_0004},
		'{32'hffff_0000, 32'h1234_e0e4, 32'h0001_0004},
		'{32'hffff_ffff, 32'h09ac_0d09, 32'h0001_0005}};
	bit_ops_top bit_ops_top_i (.clk_i(clk), .rst_i(rst), .ce_i(ce), .adr_i(adr),
		.dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat),
		.ack_o(ack), .condition_flag_o(f.condition_flag), .zero_flag_o(f.zero_flag),
		.negative_flag_o(f.negative_flag), .carry_flag_o(f.carry_flag),
		.overflow_flag_o(f.overflow_flag));
	decoder_model decoder_model_i (.clk_i(clk), .ack_i(ack), .rdat_i(rdat), .adr_o(adr),
		.dat_o(wdat), .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
	// ****
	// helpers
	// ****
	function automatic word_t dep(word_t b, word_t o, logic x);
		int p;
		int l;
		word_t r;
		p = o[12:8];
		l = (o[4:0] > 5'h10) ? 16 : o[4:0];
		r = b;
		for (int k = 0; k < l; k++)
			if (p + k < 32) r[p + k] = o[16 + k];
		if (x && p + l == 0) r = 32'h0;
		else if (x) for (int k = p + l; k < 32; k++) r[k] = r[p + l - 1];
		return r;
	endfunction : dep
	task automatic chk(input word_t s, input word_t x);
		compares++;
		if (s !== x) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input word_t d);
		word_t t;
		decoder_model_i.xfer(1'b1, a, d, t);
		// the write lands on the ack edge, so flags settle only after it
		@(negedge clk);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input word_t x);
		decoder_model_i.xfer(1'b0, a, 32'h0, q);
		chk(q, x);
	endtask : rdc
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// ****
	// tests
	// ****
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		num_errors = 0;
		compares = 0;
		ce = 1'b1;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(`ADR_FLG, 32'h0);
		rdc(`ADR_STS, 32'h0);
		rdc(8'h1c, 32'h0);
		$display("reset test done");
		w = 32'ha5c3_8421;
		wr(`ADR_OPA, w);
		wr(`ADR_FLG, 32'h1e);
		for (i = 0; i < 64; i++) begin
			wr(`ADR_CMD, (word_t'(i % 32) << 8) | (i < 32 ? 32'h1 : 32'h2));
			chk(word_t'(f), {27'h0, 4'hf, w[i % 32] ^ (i >= 32)});
		end
		rdc(`ADR_OPA, w);
		wr(`ADR_CMD, 32'h0002_0001);
		chk(word_t'(f), 32'h1e);
		wr(`ADR_CMD, 32'h0001_0001);
		chk(word_t'(f), 32'h1e);
		rdc(`ADR_STS, 32'h0000_4001);
		chk(q & 32'h1, 32'h1);
		$display("bit test done");
		wr(`ADR_OPA, 32'hf1ff_ffff);
		for (i = 0; i < 2; i++) begin
			wr(`ADR_CMD, 32'h0000_1803);
			rdc(`ADR_OPA, i ? 32'hf1ff_ffff : 32'hf0ff_ffff);
		end
		$display("toggle test done");
		for (i = 0; i < 10; i++) begin
			wr(`ADR_OPA, tbl[i][0]);
			wr(`ADR_OPB, tbl[i][1]);
			wr(`ADR_FLG, 32'h1f);
			wr(`ADR_CMD, tbl[i][2]);
			e = dep(tbl[i][0], tbl[i][1], tbl[i][2][0]);
			rdc(`ADR_RES, e);
			rdc(`ADR_OPA, tbl[i][2][21:20] == 2'h1 ? e : tbl[i][0]);
			rdc(`ADR_OPB, tbl[i][2][21:20] == 2'h2 ? e : tbl[i][1]);
			chk(word_t'(f), {27'h0, 2'b00, e[31], e == 32'h0, 1'b1});
		end
		// narrow word deposit must be refused and leave the result alone
		wr(`ADR_CMD, 32'h0000_0004);
		rdc(`ADR_RES, e);
		rdc(`ADR_STS, 32'h0000_4c01);
		chk(q & 32'h1, 32'h1);
		$display("deposit test done");
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		rdc(`ADR_RES, e);
		$display("enable test done");
		tally_and_finish;
	end
endmodule : tb_top
